// *** bench/stc_ext_clk.sv ***
// Model of the external count clock pin and the auxiliary oscillator
`timescale 1ns/10ps
`default_nettype none
module stc_ext_clk
(
	input  wire logic i_osc_run,
	output logic      o_pin,
	output logic      o_osc
);
	initial
	begin
		o_pin = 1'b0;
		o_osc = 1'b0;
	end
	// Pin and oscillator sit low between bursts; a disabled oscillator never toggles
	task automatic pulses(input int n);
		repeat (n)
		begin
			if (i_osc_run)
				o_osc = 1'b1;
			else
				o_pin = 1'b1;
			#20;
			o_osc = 1'b0;
			o_pin = 1'b0;
			#20;
		end
	endtask
endmodule
`default_nettype wire

// *** bench/stc_timer_test.sv ***
// Self-checking bench for the 16-bit timer/counter
`timescale 1ns/10ps
`default_nettype none
module stc_timer_test;
	typedef struct {logic [7:0] e; logic [7:0] m; string n;} stc_note_t;
	logic        i_clk = 1'b0, i_srst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
	logic        i_sysclk_from_aux_osc = 1'b0, i_special_event = 1'b0;
	logic [2:0]  i_addr = 3'h0;
	logic [7:0]  i_wdata = 8'h00, o_rdata, last = 8'h00;
	logic        o_aux_osc_run, o_osc_pins_input, o_port_read_zero, o_irq, ext_pin, osc_pin;
	logic [31:0] seed = 32'h00009dc4;
	int          mismatches = 0, n_tests = 0;
	stc_note_t   q[$];
	stc_note_t   nt;
	always #2.5 i_clk = ~i_clk;
	stc_timer u_dut (.i_clk(i_clk), .i_srst(i_srst), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ext_count_clock_pin(ext_pin),
		.i_aux_osc_in_pin(osc_pin), .i_sysclk_from_aux_osc(i_sysclk_from_aux_osc),
		.i_special_event(i_special_event), .o_aux_osc_run(o_aux_osc_run),
		.o_osc_pins_input(o_osc_pins_input), .o_port_read_zero(o_port_read_zero), .o_irq(o_irq));
	stc_ext_clk u_ext (.i_osc_run(o_aux_osc_run), .o_pin(ext_pin), .o_osc(osc_pin));
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic check(input logic [7:0] got, input logic [7:0] exp, input string nm);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic bus_wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask
	// A mask of zero reads a value only to use it as the base of a later figure
	task automatic bus_rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m,
		input string nm);
		q.push_back('{e, m, nm});
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		@(posedge i_clk);
		#1;
	endtask
	always @(posedge i_clk)
	begin
		rd_d <= i_rd;
		if (rd_d && q.size() > 0)
		begin
			nt = q.pop_front();
			last = o_rdata;
			check(o_rdata & nt.m, nt.e & nt.m, nt.n);
		end
		else if (!rd_d && !i_srst && o_rdata !== 8'h00)
			check(o_rdata, 8'h00, "idle read data");
	end
	initial
	begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		complete_run();
	end
	initial
	begin
		logic [31:0] r;
		repeat (3) @(posedge i_clk);
		i_srst <= 1'b0;
		for (int a = 0; a < 6; a++)
			bus_rd(a[2:0], 8'h00, 8'hff, "reset value");
		check({4'h0, o_aux_osc_run, o_osc_pins_input, o_port_read_zero, o_irq},
			8'h00, "outs");
		$display("reset test done");
		@(posedge i_clk);
		i_sysclk_from_aux_osc <= 1'b1;
		bus_wr(3'h5, 8'hff);
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h08);
		bus_rd(3'h5, 8'h00, 8'hff, "unmapped");
		bus_rd(stc_pkg::ADDR_CONTROL, 8'h48, 8'hff, "control");
		check({7'h0, o_aux_osc_run}, 8'h01, "osc run");
		check({7'h0, o_osc_pins_input}, 8'h00, "pins idle");
		@(posedge i_clk);
		i_sysclk_from_aux_osc <= 1'b0;
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h40);
		bus_rd(stc_pkg::ADDR_CONTROL, 8'h00, 8'hff, "read-only bit");
		$display("control test done");
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h00);
		repeat (3)
		begin
			r = xs();
			bus_wr(stc_pkg::ADDR_COUNT_HI, r[15:8]);
			bus_wr(stc_pkg::ADDR_COUNT_LOW, r[7:0]);
			bus_rd(stc_pkg::ADDR_COUNT_LOW, r[7:0], 8'hff, "count low");
			bus_rd(stc_pkg::ADDR_COUNT_HI, r[15:8], 8'hff, "count high");
		end
		@(posedge i_clk);
		i_special_event <= 1'b1;
		@(posedge i_clk);
		i_special_event <= 1'b0;
		bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h00, 8'hff, "trigger low");
		bus_rd(stc_pkg::ADDR_COUNT_HI, 8'h00, 8'hff, "trigger high");
		$display("count access test done");
		// Read edges sit exactly 16 prescaled ticks (64 << p clocks) apart, so the phase cancels out
		for (int p = 0; p < 4; p++)
		begin
			r = xs();
			bus_wr(stc_pkg::ADDR_CONTROL, {2'b00, p[1:0], 1'b0, r[0], 2'b01});
			bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "base");
			repeat ((64 << p) - 3) @(posedge i_clk);
			bus_rd(stc_pkg::ADDR_COUNT_LOW, last + 8'h10, 8'hff, "timer");
			check({6'h0, o_osc_pins_input, o_port_read_zero}, 8'h03, "pins");
		end
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h00);
		bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "base");
		repeat (40) @(posedge i_clk);
		bus_rd(stc_pkg::ADDR_COUNT_LOW, last, 8'hff, "stopped");
		$display("timer test done");
		for (int m = 0; m < 4; m++)
		begin
			bus_wr(stc_pkg::ADDR_CONTROL, {4'b0001, m[1], m[0], 2'b11});
			bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "base");
			u_ext.pulses(20);
			repeat (10) @(posedge i_clk);
			bus_rd(stc_pkg::ADDR_COUNT_LOW, last + 8'h0a, 8'hff, "ext");
		end
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h00);
		$display("counter test done");
		bus_wr(stc_pkg::ADDR_COUNT_HI, 8'hff);
		bus_wr(stc_pkg::ADDR_COUNT_LOW, 8'hfe);
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h01);
		repeat (20) @(posedge i_clk);
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h00);
		bus_rd(stc_pkg::ADDR_IRQ_STAT, 8'h01, 8'hff, "overflow");
		check({7'h0, o_irq}, 8'h00, "masked irq");
		bus_wr(stc_pkg::ADDR_IRQ_MASK, 8'h01);
		repeat (2) @(posedge i_clk);
		#1 check({7'h0, o_irq}, 8'h01, "irq");
		bus_wr(stc_pkg::ADDR_IRQ_STAT, 8'h00);
		bus_rd(stc_pkg::ADDR_IRQ_STAT, 8'h01, 8'hff, "sticky");
		bus_wr(stc_pkg::ADDR_IRQ_STAT, 8'h01);
		bus_rd(stc_pkg::ADDR_IRQ_STAT, 8'h00, 8'hff, "cleared");
		check({7'h0, o_irq}, 8'h00, "irq off");
		$display("interrupt test done");
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h80);
		bus_wr(stc_pkg::ADDR_COUNT_HI, 8'h12);
		bus_wr(stc_pkg::ADDR_COUNT_LOW, 8'hfc);
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h81);
		bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h00, 8'h00, "base");
		repeat (40) @(posedge i_clk);
		bus_rd(stc_pkg::ADDR_COUNT_HI, 8'h12, 8'hff, "wide high");
		bus_wr(stc_pkg::ADDR_CONTROL, 8'h80);
		bus_wr(stc_pkg::ADDR_COUNT_HI, 8'h56);
		bus_wr(stc_pkg::ADDR_COUNT_LOW, 8'h78);
		bus_rd(stc_pkg::ADDR_COUNT_LOW, 8'h78, 8'hff, "wide low");
		bus_rd(stc_pkg::ADDR_COUNT_HI, 8'h56, 8'hff, "wide high");
		$display("wide access test done");
		complete_run();
	end
endmodule
`default_nettype wire

// *** rtl/stc_pkg.sv ***
// Package: register map, field positions and reset values of the 16-bit timer/counter
package stc_pkg;
	localparam logic [2:0] ADDR_CONTROL   = 3'h0;
	localparam logic [2:0] ADDR_COUNT_LOW = 3'h1;
	localparam logic [2:0] ADDR_COUNT_HI  = 3'h2;
	localparam logic [2:0] ADDR_IRQ_STAT  = 3'h3;
	localparam logic [2:0] ADDR_IRQ_MASK  = 3'h4;
	localparam int BIT_COUNT_ON    = 0;
	localparam int BIT_CLK_SRC     = 1;
	localparam int BIT_SYNC_BYPASS = 2;
	localparam int BIT_OSC_EN      = 3;
	localparam int BIT_PRESC_LO    = 4;
	localparam int BIT_PRESC_HI    = 5;
	localparam int BIT_SYSCLK_AUX  = 6;
	localparam int BIT_WIDE        = 7;
	localparam int BIT_IRQ_OVF     = 0;
	localparam int INSTR_DIV       = 4;
	localparam logic [7:0]  CONTROL_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET   = 16'h0000;
	localparam logic [7:0]  IRQ_RESET     = 8'h00;
	localparam logic [7:0]  RO_MASK       = 8'h40;

	typedef enum logic [1:0]
	{
		STC_MODE_TIMER = 2'b00,
		STC_MODE_SYNC  = 2'b01,
		STC_MODE_ASYNC = 2'b11
	} stc_mode_t;

	typedef struct packed
	{
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} stc_bus_req_t;
endpackage

// *** rtl/stc_timer.sv ***
// 16-bit timer/counter with prescaler, byte-wide count access and overflow interrupt
//
// Decided for this implementation: strobed register access and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module stc_timer
(
	input  wire logic       i_clk,
	input  wire logic       i_srst,
	input  wire logic [2:0] i_addr,
	input  wire logic [7:0] i_wdata,
	input  wire logic       i_wr,
	input  wire logic       i_rd,
	output logic      [7:0] o_rdata,
	input  wire logic       i_ext_count_clock_pin,
	input  wire logic       i_aux_osc_in_pin,
	input  wire logic       i_sysclk_from_aux_osc,
	input  wire logic       i_special_event,
	output logic            o_aux_osc_run,
	output logic            o_osc_pins_input,
	output logic            o_port_read_zero,
	output logic            o_irq
);
	stc_pkg::stc_bus_req_t bus;
	logic [7:0]  control_reg;
	logic [15:0] count_reg;
	logic [15:0] count_next;
	logic [7:0]  high_buf_reg;
	logic [7:0]  wr_high_buf_reg;
	logic [7:0]  irq_stat_reg;
	logic [7:0]  irq_mask_reg;
	logic [1:0]  qdiv_reg;
	logic        instr_tick;
	logic [1:0]  ext_meta_reg;
	logic [1:0]  ext_sync_reg;
	logic        ext_prev_reg;
	logic        ext_sync_edge;
	logic        ext_raw_prev_reg;
	logic        ext_sel;
	logic        ext_raw_edge;
	logic        src_tick;
	logic [2:0]  presc_reg;
	logic [2:0]  presc_top;
	logic        count_tick;
	logic        overflow;
	logic        sysclk_meta_reg;
	logic        sysclk_sync_reg;
	stc_pkg::stc_mode_t mode;

	assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

	// Operating mode decode; sync bit only matters with the external source
	always_comb
	begin
		if (!control_reg[stc_pkg::BIT_CLK_SRC])
			mode = stc_pkg::STC_MODE_TIMER;
		else if (control_reg[stc_pkg::BIT_SYNC_BYPASS])
			mode = stc_pkg::STC_MODE_ASYNC;
		else
			mode = stc_pkg::STC_MODE_SYNC;
	end

	// Instruction cycle enable: one pulse every four clocks
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			qdiv_reg <= 2'h0;
		else
			qdiv_reg <= qdiv_reg + 2'h1;
	end
	assign instr_tick = (qdiv_reg == 2'(stc_pkg::INSTR_DIV - 1));

	// External source: pin or auxiliary oscillator when that oscillator runs.
	// Both pins are synchronised before the select, so switching sources
	// while the new one is high can count one false edge
	assign ext_sel = control_reg[stc_pkg::BIT_OSC_EN] ? ext_sync_reg[1]
		: ext_sync_reg[0];

	// Two-flop synchroniser per pin; only the second flop feeds the edge logic
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			ext_meta_reg     <= 2'h0;
			ext_sync_reg     <= 2'h0;
			ext_prev_reg     <= 1'b0;
			ext_raw_prev_reg <= 1'b0;
		end
		else
		begin
			ext_meta_reg     <= {i_aux_osc_in_pin, i_ext_count_clock_pin};
			ext_sync_reg     <= ext_meta_reg;
			ext_prev_reg     <= ext_sel;
			ext_raw_prev_reg <= ext_prev_reg;
		end
	end
	// Synchronised mode takes the edge one cycle after the synchroniser output;
	// unsynchronised mode takes it at once, one cycle earlier
	assign ext_raw_edge  = ext_sel & ~ext_prev_reg;
	assign ext_sync_edge = ext_prev_reg & ~ext_raw_prev_reg;

	always_comb
	begin
		case (mode)
			stc_pkg::STC_MODE_TIMER: src_tick = instr_tick;
			stc_pkg::STC_MODE_SYNC:  src_tick = ext_sync_edge;
			stc_pkg::STC_MODE_ASYNC: src_tick = ext_raw_edge;
			default:                 src_tick = 1'b0;
		endcase
	end

	// Prescaler: terminal count 0, 1, 3 or 7 selects 1:1 to 1:8
	assign presc_top = 3'((4'h1 << {control_reg[stc_pkg::BIT_PRESC_HI],
		control_reg[stc_pkg::BIT_PRESC_LO]}) - 4'h1);

	always_ff @(posedge i_clk)
	begin
		if (i_srst || !control_reg[stc_pkg::BIT_COUNT_ON])
			presc_reg <= 3'h0;
		else if (src_tick)
			presc_reg <= (presc_reg >= presc_top) ? 3'h0 : presc_reg + 3'h1;
	end
	assign count_tick = control_reg[stc_pkg::BIT_COUNT_ON] & src_tick
		& (presc_reg >= presc_top);

	assign overflow = count_tick && (count_reg == 16'hffff);

	// Control register; bit 6 is status, never written
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			control_reg <= stc_pkg::CONTROL_RESET;
		else if (bus.wr && bus.addr == stc_pkg::ADDR_CONTROL)
			control_reg <= bus.wdata & ~stc_pkg::RO_MASK;
	end

	// System clock status comes from the clock controller, another domain
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			sysclk_meta_reg <= 1'b0;
			sysclk_sync_reg <= 1'b0;
		end
		else
		begin
			sysclk_meta_reg <= i_sysclk_from_aux_osc;
			sysclk_sync_reg <= sysclk_meta_reg;
		end
	end

	// Count: trigger clear beats a write, a write beats counting
	always_comb
	begin
		count_next = count_reg;
		if (i_special_event)
			count_next = stc_pkg::COUNT_RESET;
		else if (bus.wr && bus.addr == stc_pkg::ADDR_COUNT_LOW)
		begin
			if (control_reg[stc_pkg::BIT_WIDE])
				count_next = {wr_high_buf_reg, bus.wdata};
			else
				count_next = {count_reg[15:8], bus.wdata};
		end
		else if (bus.wr && bus.addr == stc_pkg::ADDR_COUNT_HI
			&& !control_reg[stc_pkg::BIT_WIDE])
			count_next = {bus.wdata, count_reg[7:0]};
		else if (count_tick)
			count_next = count_reg + 16'h0001;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			count_reg <= stc_pkg::COUNT_RESET;
		else
			count_reg <= count_next;
	end

	// Wide mode: low-byte read latches the high byte; high-byte write is held
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
		begin
			high_buf_reg    <= 8'h00;
			wr_high_buf_reg <= 8'h00;
		end
		else
		begin
			if (bus.rd && bus.addr == stc_pkg::ADDR_COUNT_LOW)
				high_buf_reg <= count_reg[15:8];
			if (bus.wr && bus.addr == stc_pkg::ADDR_COUNT_HI)
				wr_high_buf_reg <= bus.wdata;
		end
	end

	// Sticky flag: a new overflow wins over a write-one clear
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			irq_stat_reg <= stc_pkg::IRQ_RESET;
		else
		begin
			if (bus.wr && bus.addr == stc_pkg::ADDR_IRQ_STAT)
				irq_stat_reg <= irq_stat_reg & ~bus.wdata;
			if (overflow)
				irq_stat_reg[stc_pkg::BIT_IRQ_OVF] <= 1'b1;
		end
	end

	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			irq_mask_reg <= stc_pkg::IRQ_RESET;
		else if (bus.wr && bus.addr == stc_pkg::ADDR_IRQ_MASK)
			irq_mask_reg <= bus.wdata;
	end

	assign o_irq = |(irq_stat_reg & irq_mask_reg);

	// Read data, one cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge i_clk)
	begin
		if (i_srst)
			o_rdata <= 8'h00;
		else if (bus.rd)
		begin
			case (bus.addr)
				stc_pkg::ADDR_CONTROL:   o_rdata <= {control_reg[7],
					sysclk_sync_reg, control_reg[5:0]};
				stc_pkg::ADDR_COUNT_LOW: o_rdata <= count_reg[7:0];
				stc_pkg::ADDR_COUNT_HI:  o_rdata <= control_reg[stc_pkg::BIT_WIDE]
					? high_buf_reg : count_reg[15:8];
				stc_pkg::ADDR_IRQ_STAT:  o_rdata <= irq_stat_reg;
				stc_pkg::ADDR_IRQ_MASK:  o_rdata <= irq_mask_reg;
				default:                 o_rdata <= 8'h00;
			endcase
		end
		else
			o_rdata <= 8'h00;
	end

	// Oscillator amplifier on only when enabled, saving its bias current
	assign o_aux_osc_run    = control_reg[stc_pkg::BIT_OSC_EN];
	assign o_osc_pins_input = control_reg[stc_pkg::BIT_COUNT_ON];
	assign o_port_read_zero = control_reg[stc_pkg::BIT_COUNT_ON];

	// Checks
	// Steps of multi-cycle behaviours
	sequence pin_rise_s;
		control_reg[stc_pkg::BIT_CLK_SRC] && $rose(control_reg[stc_pkg::BIT_OSC_EN]
			? i_aux_osc_in_pin : i_ext_count_clock_pin);
	endsequence
	sequence wide_hi_wr_s;
		i_wr && i_addr == stc_pkg::ADDR_COUNT_HI && control_reg[stc_pkg::BIT_WIDE];
	endsequence
	sequence wide_lo_wr_s;
		i_wr && i_addr == stc_pkg::ADDR_COUNT_LOW && control_reg[stc_pkg::BIT_WIDE]
			&& !i_special_event;
	endsequence
	sequence wide_lo_rd_s;
		i_rd && i_addr == stc_pkg::ADDR_COUNT_LOW && control_reg[stc_pkg::BIT_WIDE];
	endsequence
	sequence wide_hi_rd_s;
		i_rd && i_addr == stc_pkg::ADDR_COUNT_HI && control_reg[stc_pkg::BIT_WIDE];
	endsequence
	stop_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
		!control_reg[0] && !i_special_event && !i_wr |=> $stable(count_reg))
		else $error("count moved while stopped");
	prescale_one_a: assert property (@(posedge i_clk) disable iff (i_srst)
		control_reg[5:4] == 2'b00 && control_reg[0] && src_tick |-> count_tick)
		else $error("1:1 prescale dropped a tick");
	timer_rate_a: assert property (@(posedge i_clk) disable iff (i_srst)
		count_tick && mode == stc_pkg::STC_MODE_TIMER && control_reg[5:4] == 2'b00
		|=> !count_tick [*3])
		else $error("timer faster than instruction rate");
	trig_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_special_event |=> count_reg == 16'h0000)
		else $error("trigger did not clear count");
	ovf_sticky_a: assert property (@(posedge i_clk) disable iff (i_srst)
		overflow |=> irq_stat_reg[0])
		else $error("overflow flag not set");
	irq_level_a: assert property (@(posedge i_clk) disable iff (i_srst)
		irq_stat_reg[0] && irq_mask_reg[0] |-> o_irq)
		else $error("masked-in flag gave no interrupt");
	ro_bit_a: assert property (@(posedge i_clk) disable iff (i_srst)
		!control_reg[6])
		else $error("status bit stored in control");
	pins_in_a: assert property (@(posedge i_clk) disable iff (i_srst)
		control_reg[0] |-> o_osc_pins_input && o_port_read_zero)
		else $error("pins not forced to input");
	osc_gate_a: assert property (@(posedge i_clk) disable iff (i_srst)
		o_aux_osc_run == control_reg[3])
		else $error("oscillator enable mismatch");
	async_sel_a: assert property (@(posedge i_clk) disable iff (i_srst)
		control_reg[1] && control_reg[2] |-> src_tick == ext_raw_edge)
		else $error("async mode not on raw edge");
	ignore_sync_a: assert property (@(posedge i_clk) disable iff (i_srst)
		!control_reg[1] |-> src_tick == instr_tick)
		else $error("sync bit affected timer mode");
	mode_dec_a: assert property (@(posedge i_clk) disable iff (i_srst)
		control_reg[1] && !control_reg[2] |-> mode == stc_pkg::STC_MODE_SYNC)
		else $error("mode decode wrong");
	ext_edge_a: assert property (@(posedge i_clk) disable iff (i_srst)
		control_reg[1] && !control_reg[2] && ext_sync_edge |-> src_tick)
		else $error("external edge missed");
	low_rw_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_rd && i_addr == 3'h1 |=> o_rdata == $past(count_reg[7:0]))
		else $error("low byte read wrong");
	wide_rd_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_rd && i_addr == 3'h1 |=> high_buf_reg == $past(count_reg[15:8]))
		else $error("high byte not latched");
	async_lat_a: assert property (@(posedge i_clk) disable iff (i_srst)
		pin_rise_s ##0 control_reg[stc_pkg::BIT_SYNC_BYPASS] |-> ##2 src_tick)
		else $error("unsynchronised edge not counted");
	sync_lat_a: assert property (@(posedge i_clk) disable iff (i_srst)
		pin_rise_s ##0 !control_reg[stc_pkg::BIT_SYNC_BYPASS] |-> ##3 src_tick)
		else $error("synchronised edge not counted");
	wide_write_a: assert property (@(posedge i_clk) disable iff (i_srst)
		wide_hi_wr_s ##1 !i_wr ##1 wide_lo_wr_s
		|=> count_reg == {$past(i_wdata, 3), $past(i_wdata)})
		else $error("wide write not loaded as one");
	wide_pair_a: assert property (@(posedge i_clk) disable iff (i_srst)
		wide_lo_rd_s ##1 !i_rd [*2] ##1 wide_hi_rd_s
		|=> o_rdata == $past(count_reg[15:8], 4))
		else $error("wide read pair split");
	stat_clear_a: assert property (@(posedge i_clk) disable iff (i_srst)
		i_wr && i_addr == stc_pkg::ADDR_IRQ_STAT && i_wdata[0] && !overflow
		|=> !irq_stat_reg[0])
		else $error("write one did not clear flag");
	stat_hold_a: assert property (@(posedge i_clk) disable iff (i_srst)
		irq_stat_reg[0] && !(i_wr && i_addr == stc_pkg::ADDR_IRQ_STAT)
		|=> irq_stat_reg[0])
		else $error("flag dropped without clear");
endmodule
`default_nettype wire
